// >>> hw/rss_cfg.svh
// reset and start-up sequencer: constants, offsets, reset values and timing counts
// assumes a 125 MHz core clock and a backplane frame of 8 kHz
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH

// core clock and derived timing
`define RSS_CLK_PERIOD_NS 8
`define RSS_MR_FILT_NS 90
`define RSS_MR_GUAR_US 2
`define RSS_MR_FILT_CYC ((`RSS_MR_FILT_NS + `RSS_CLK_PERIOD_NS - 1) / `RSS_CLK_PERIOD_NS)
`define RSS_FRAME_US 125
`define RSS_FRAME_TMO_CYC ((`RSS_FRAME_US * 1000 * 3 / 2) / `RSS_CLK_PERIOD_NS)
`define RSS_SW_RST_CYC 16
`define RSS_MODE_DELAY_FRM 2

// data clock rising edges expected per frame
`define RSS_DCL_PER_FRM_2M 10'h100
`define RSS_DCL_PER_FRM_4M 10'h200

// command byte and config bit positions
`define RSS_SOP_RST_BIT 4
`define RSS_CR6_FIXED_COEFF_SELECT_BIT 0
`define RSS_CI_RING 5
`define RSS_CI_CONV 4
`define RSS_CI_O1 0

// idle codes of the two companding laws
`define RSS_IDLE_ALAW 8'hD5
`define RSS_IDLE_ULAW 8'hFF

// reset values of control state
`define RSS_SIGMASK_RST 6'h3F
`define RSS_CIUP_RST 6'h00
`define RSS_IODIR_RST 2'h0

// start-up defaults (currents in 0.1 mA, gains in dBr)
`define RSS_DEF_PERSIST_HOOK_MS 8'h0A
`define RSS_DEF_PERSIST_GK_MS 8'h14
`define RSS_DEF_RINGTRIP 8'h2A
`define RSS_DEF_ILIM_ACT 8'hDC
`define RSS_DEF_ILIM_STBY 8'h4D
`define RSS_DEF_OFFHOOK_ACT 8'h64
`define RSS_DEF_OFFHOOK_STBY 8'h4D
`define RSS_DEF_RING_HZ 8'h19
`define RSS_DEF_RING_VRMS 8'h41
`define RSS_DEF_TTX_KHZ 8'h10
`define RSS_DEF_TTX_VRMS 8'h0A
`define RSS_DEF_TX_GAIN 8'h00
`define RSS_DEF_RX_GAIN 8'hF9

// fixed coefficient set, entry 0 in the low word
`define RSS_COEF_WORDS 23
`define RSS_FIXED_TABLE {16'h3C80, 16'h0000, 16'h06D0, 16'h0680, 16'h0050, 16'h0000, 16'h0000, 16'h0000, \
  16'h0060, 16'h00FF, 16'h0006, 16'h00B4, 16'h39E0, 16'h1879, 16'h3EF2, 16'h3F40, 16'h0521, 16'h149A, \
  16'h1600, 16'h24A0, 16'h019C, 16'h0E00, 16'h0E00}

`endif

// >>> hw/rss_pkg.sv
// reset and start-up sequencer: shared types
// assumes rss_cfg.svh holds every number
package rss_pkg;
  // reset sequencer states
  typedef enum logic [1:0] {
    ST_RUN      = 2'b00,
    ST_HARD     = 2'b01,
    ST_SOFTWAIT = 2'b10,
    ST_SOFT     = 2'b11
  } rss_state_e;
  // one coefficient word and its address
  typedef logic [15:0] rss_coef_t;
  typedef logic [4:0] rss_caddr_t;
  // start-up default settings
  typedef struct packed {
    logic [7:0] persistHookMs;
    logic [7:0] persistGkMs;
    logic [7:0] ringTrip;
    logic [7:0] ilimAct;
    logic [7:0] ilimStby;
    logic [7:0] offHookAct;
    logic [7:0] offHookStby;
    logic [7:0] ringHz;
    logic [7:0] ringVrms;
    logic [7:0] ttxKhz;
    logic [7:0] ttxVrms;
    logic [7:0] txGain;
    logic [7:0] rxGain;
    logic ringInternal;
    logic hardReversal;
  } rss_dflt_s;
endpackage

// >>> hw/rss_coef_if.sv
// reset and start-up sequencer: coefficient store carrier
// assumes both ends run on core_clk
`timescale 1ns/100ps
interface rss_coef_if;
  import rss_pkg::*;
  logic wrEn; // write strobe
  rss_caddr_t wrAddr;
  rss_coef_t wrData;
  rss_caddr_t rdAddrA; // dsp fetch port
  rss_caddr_t rdAddrB; // readback and checksum port
  rss_coef_t rdDataA;
  rss_coef_t rdDataB;
  modport ctl (output wrEn, wrAddr, wrData, rdAddrA, rdAddrB, input rdDataA, rdDataB);
  modport mem (input wrEn, wrAddr, wrData, rdAddrA, rdAddrB, output rdDataA, rdDataB);
endinterface

// >>> hw/rss_coef_mem.sv
// reset and start-up sequencer: programmed coefficient store
// assumes one write port and two read ports, read data registered
`timescale 1ns/100ps
`include "rss_cfg.svh"
module rss_coef_mem
  import rss_pkg::*;
(
  // clock and control
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // carrier
  rss_coef_if.mem cif
);
  // array is not reset: programmed coefficients survive every reset
  rss_coef_t store [`RSS_COEF_WORDS];

  // write port
  always_ff @(posedge core_clk) begin
    if (clkEn && cif.wrEn && (cif.wrAddr < 5'(`RSS_COEF_WORDS))) begin
      store[cif.wrAddr] <= cif.wrData;
    end
  end

  // registered reads, out-of-range reads give zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cif.rdDataA <= 16'h0000;
      cif.rdDataB <= 16'h0000;
    end else if (clkEn) begin
      cif.rdDataA <= (cif.rdAddrA < 5'(`RSS_COEF_WORDS)) ? store[cif.rdAddrA] : 16'h0000;
      cif.rdDataB <= (cif.rdAddrB < 5'(`RSS_COEF_WORDS)) ? store[cif.rdAddrB] : 16'h0000;
    end
  end
endmodule

// >>> hw/rss_reset_startup.sv
// reset and start-up sequencer: reset merge, pin states, clock-fail reset, start-up defaults
// assumes pins arrive unsynchronised; command strobes come from logic on core_clk
//
// What this block does
// - any reset forces external indication, power denial
// - resets from power-on, reset pin, software bit
// - reset pin ignores short spikes, long ones reset
// - during reset: float data and power-down, drive pins
// - software reset waits for current command end
// - clock fail resets dsp until good frame
// - clock fail in active: idle code, mute
// - clock fail keeps coefficients, config, link state
// - after reset use defaults, keep programmed coefficients
// - reset sets fixed-coefficient flag until cleared
// - checksum and readback use programmed coefficients
// - fixed set holds the documented coefficient words
// - line mode applied two frames after reset
// - reset bit reads one after any reset
// - hardware reset clears link, software keeps it
// - reset makes io inputs, clears power-up bit
// - reset masks signalling bits, clears upstream byte
// - default persistence 10ms hook, 20ms ground key
// - default dc thresholds and current limits
// - default ringing 25Hz 65Vrms, A-law coding
// - default ac metering, gains, hard reversal
// - downstream command latched after two equal frames
`timescale 1ns/100ps
`include "rss_cfg.svh"
module rss_reset_startup
  import rss_pkg::*;
#(
  parameter int FRAME_TMO_CYC = `RSS_FRAME_TMO_CYC
)(
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // asynchronous pins
  input wire logic powerOnDet,
  input wire logic masterResetPin,
  input wire logic dataClk,
  input wire logic frameSync,
  input wire logic sel4M,
  // command path (core_clk)
  input wire logic cmdBusy,
  input wire logic sopWrite,
  input wire logic [7:0] sopData,
  input wire logic cr6Write,
  input wire logic [7:0] cr6Data,
  input wire logic cr1Write,
  input wire logic cr1PowerUp,
  input wire logic ioDirWrite,
  input wire logic [1:0] ioDirData,
  input wire logic sigMaskWrite,
  input wire logic [5:0] sigMaskData,
  input wire logic lawWrite,
  input wire logic lawMuData,
  input wire logic ciUpLoad,
  input wire logic [5:0] ciUpData,
  input wire logic ciRxStrobe,
  input wire logic [5:0] ciDownRx,
  input wire logic duDriveReq,
  input wire logic pdoDriveReq,
  input wire logic pdoLevel,
  // coefficient access
  input wire logic coefWrEn,
  input wire logic [4:0] coefWrAddr,
  input wire logic [15:0] coefWrData,
  input wire logic [4:0] dspCoefAddr,
  input wire logic [4:0] readAddr,
  input wire logic chksumStart,
  // reset state outputs
  output logic coreRst_r,
  output logic gciRst_r,
  output logic dspRst_r,
  output logic extIndication_r,
  output logic powerDenial_r,
  // pin drives
  output logic lineDriverModeOutA_r,
  output logic lineDriverModeOutB_r,
  output logic duOe_r,
  output logic pdoOut_r,
  output logic pdoOe_r,
  output logic fixedOutputPin_r,
  // clock-fail voice handling
  output logic clkFail_r,
  output logic idleInsert_r,
  output logic [7:0] idleCode_r,
  output logic rxMute_r,
  // status and config
  output logic rstFlag_r,
  output logic fixedCoeffSelect_r,
  output logic powerUpBit_r,
  output logic [1:0] ioDir_r,
  output logic [5:0] sigMask_r,
  output logic [5:0] ciUp_r,
  output logic lawMu_r,
  output logic [5:0] modeApplied_r,
  output rss_dflt_s defaults_r,
  // coefficient results
  output logic [15:0] dspCoef_r,
  output logic [15:0] readData_r,
  output logic [15:0] chksum_r,
  output logic chksumBusy_r
);
  localparam int MR_CYC = `RSS_MR_FILT_CYC;
  localparam logic [`RSS_COEF_WORDS*16-1:0] FIXED_TABLE = `RSS_FIXED_TABLE;

  // pin synchronisers, one two-stage chain per pin
  logic [4:0] pinRaw; // pins in a bus
  logic [4:0] pinMeta_r; // first stage, read only by second
  logic [4:0] pinSync_r; // second stage
  assign pinRaw = {sel4M, frameSync, dataClk, masterResetPin, powerOnDet};
  for (genvar i = 0; i < 5; i++) begin : g_sync
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        pinMeta_r[i] <= 1'b0;
        pinSync_r[i] <= 1'b0;
      end else if (clkEn) begin
        pinMeta_r[i] <= pinRaw[i];
        pinSync_r[i] <= pinMeta_r[i];
      end
    end
  end
  wire porS = pinSync_r[0];
  wire mrS = pinSync_r[1];
  wire dclS = pinSync_r[2];
  wire fscS = pinSync_r[3];
  wire sel4S = pinSync_r[4];

  // reset pin spike filter: a high level must persist MR_CYC cycles
  logic [3:0] mrFiltCnt_r;
  logic pinRst_r;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mrFiltCnt_r <= 4'h0;
      pinRst_r <= 1'b0;
    end else if (clkEn) begin
      if (!mrS) begin // low: restart the qualification
        mrFiltCnt_r <= 4'h0;
        pinRst_r <= 1'b0;
      end else if (mrFiltCnt_r == 4'(MR_CYC - 1)) begin
        pinRst_r <= 1'b1;
      end else begin
        mrFiltCnt_r <= mrFiltCnt_r + 4'h1;
      end
    end
  end

  // reset sequencer: hard sources win over a pending software reset
  rss_state_e state_r, state_nxt;
  logic [3:0] swCnt_r;
  wire hardSrc = porS | pinRst_r;
  wire swReq = sopWrite & sopData[`RSS_SOP_RST_BIT];
  wire swDone = (swCnt_r == 4'(`RSS_SW_RST_CYC - 1));
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (hardSrc) state_nxt = ST_HARD;
        else if (swReq && cmdBusy) state_nxt = ST_SOFTWAIT;
        else if (swReq) state_nxt = ST_SOFT;
      end
      ST_HARD: begin
        if (!hardSrc) state_nxt = ST_RUN;
      end
      ST_SOFTWAIT: begin
        // core stays out of reset until the command in flight completes
        if (hardSrc) state_nxt = ST_HARD;
        else if (!cmdBusy) state_nxt = ST_SOFT;
      end
      ST_SOFT: begin
        if (hardSrc) state_nxt = ST_HARD;
        else if (swDone) state_nxt = ST_RUN;
      end
      default: state_nxt = ST_HARD;
    endcase
  end
  // merged internal reset, already on core_clk
  wire coreRst_nxt = (state_nxt == ST_HARD) || (state_nxt == ST_SOFT);
  wire gciRst_nxt = (state_nxt == ST_HARD);

  // state register and soft reset length
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_HARD;
      swCnt_r <= 4'h0;
    end else if (clkEn) begin
      state_r <= state_nxt;
      swCnt_r <= (state_r == ST_SOFT) ? swCnt_r + 4'h1 : 4'h0;
    end
  end

  // frame edge detection on the synchronised link pins
  logic dclQ_r, fscQ_r;
  logic [9:0] dclCnt_r; // data clock edges since last frame edge
  logic [15:0] tmoCnt_r; // cycles since last frame edge or timeout
  wire dclRise = dclS & ~dclQ_r;
  wire fscRise = fscS & ~fscQ_r;
  wire [9:0] frmEdges = dclCnt_r + {9'h000, dclRise};
  wire [9:0] expEdges = sel4S ? `RSS_DCL_PER_FRM_4M : `RSS_DCL_PER_FRM_2M;
  wire goodFrame = (frmEdges == expEdges);
  wire frameTmo = (tmoCnt_r == 16'(FRAME_TMO_CYC - 1));
  // failed frame sets, first good frame clears
  wire clkFail_nxt = (fscRise && goodFrame) ? 1'b0 : ((fscRise || frameTmo) ? 1'b1 : clkFail_r);

  // edge counters, saturating so a runaway clock cannot wrap to a good count
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dclQ_r <= 1'b0;
      fscQ_r <= 1'b0;
      dclCnt_r <= 10'h000;
      tmoCnt_r <= 16'h0000;
    end else if (clkEn) begin
      dclQ_r <= dclS;
      fscQ_r <= fscS;
      if (fscRise) dclCnt_r <= 10'h000;
      else if (dclRise && dclCnt_r != 10'h3FF) dclCnt_r <= dclCnt_r + 10'h001;
      if (fscRise || frameTmo) tmoCnt_r <= 16'h0000;
      else tmoCnt_r <= tmoCnt_r + 16'h0001;
    end
  end

  // downstream command: accept only two equal consecutive frames
  logic [5:0] ciPrev_r, ciLatch_r;
  logic [1:0] frmSinceRst_r;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ciPrev_r <= 6'h00;
      ciLatch_r <= 6'h00;
    end else if (clkEn) begin
      if (gciRst_nxt) begin // only a hard reset clears link state
        ciPrev_r <= 6'h00;
        ciLatch_r <= 6'h00;
      end else if (ciRxStrobe) begin
        ciPrev_r <= ciDownRx;
        if (ciDownRx == ciPrev_r) ciLatch_r <= ciDownRx;
      end
    end
  end

  // frame count after reset gates the mode hand-over
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      frmSinceRst_r <= 2'h0;
      modeApplied_r <= 6'h00;
    end else if (clkEn) begin
      if (coreRst_nxt) begin
        frmSinceRst_r <= 2'h0;
        modeApplied_r <= 6'h00;
      end else begin
        if (fscRise && frmSinceRst_r != 2'(`RSS_MODE_DELAY_FRM)) frmSinceRst_r <= frmSinceRst_r + 2'h1;
        if (frmSinceRst_r == 2'(`RSS_MODE_DELAY_FRM)) modeApplied_r <= ciLatch_r;
      end
    end
  end

  // software-visible config; set by reset wins over a same-cycle write
  logic lawMu_nxt;
  assign lawMu_nxt = coreRst_nxt ? 1'b0 : (lawWrite ? lawMuData : lawMu_r);
  wire powerUp_nxt = coreRst_nxt ? 1'b0 : (cr1Write ? cr1PowerUp : powerUpBit_r);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstFlag_r <= 1'b1;
      fixedCoeffSelect_r <= 1'b1;
      powerUpBit_r <= 1'b0;
      ioDir_r <= `RSS_IODIR_RST;
      sigMask_r <= `RSS_SIGMASK_RST;
      ciUp_r <= `RSS_CIUP_RST;
      lawMu_r <= 1'b0;
    end else if (clkEn) begin
      // reset bit reads one until software writes it zero
      if (coreRst_nxt) rstFlag_r <= 1'b1;
      else if (sopWrite && !sopData[`RSS_SOP_RST_BIT]) rstFlag_r <= 1'b0;
      if (coreRst_nxt) fixedCoeffSelect_r <= 1'b1;
      else if (cr6Write) fixedCoeffSelect_r <= cr6Data[`RSS_CR6_FIXED_COEFF_SELECT_BIT];
      powerUpBit_r <= powerUp_nxt;
      if (coreRst_nxt) ioDir_r <= `RSS_IODIR_RST;
      else if (ioDirWrite) ioDir_r <= ioDirData;
      if (coreRst_nxt) sigMask_r <= `RSS_SIGMASK_RST;
      else if (sigMaskWrite) sigMask_r <= sigMaskData;
      if (coreRst_nxt) ciUp_r <= `RSS_CIUP_RST;
      else if (ciUpLoad) ciUp_r <= ciUpData;
      lawMu_r <= lawMu_nxt;
    end
  end

  // start-up defaults, reloaded by every reset; coreRst_r covers the edge out of power-up reset
  rss_dflt_s dflt;
  assign dflt = '{persistHookMs: `RSS_DEF_PERSIST_HOOK_MS, persistGkMs: `RSS_DEF_PERSIST_GK_MS,
                  ringTrip: `RSS_DEF_RINGTRIP, ilimAct: `RSS_DEF_ILIM_ACT, ilimStby: `RSS_DEF_ILIM_STBY,
                  offHookAct: `RSS_DEF_OFFHOOK_ACT, offHookStby: `RSS_DEF_OFFHOOK_STBY,
                  ringHz: `RSS_DEF_RING_HZ, ringVrms: `RSS_DEF_RING_VRMS, ringInternal: 1'b1,
                  ttxKhz: `RSS_DEF_TTX_KHZ, ttxVrms: `RSS_DEF_TTX_VRMS, txGain: `RSS_DEF_TX_GAIN,
                  rxGain: `RSS_DEF_RX_GAIN, hardReversal: 1'b1};
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) defaults_r <= '0;
    else if (clkEn && (coreRst_nxt || coreRst_r)) defaults_r <= dflt;
  end

  // pin and reset outputs, all registered, all but pdoOut_r from the next-state terms
  wire activeMode = modeApplied_r[`RSS_CI_CONV] & ~modeApplied_r[`RSS_CI_RING];
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      coreRst_r <= 1'b1;
      gciRst_r <= 1'b1;
      dspRst_r <= 1'b1;
      extIndication_r <= 1'b1;
      powerDenial_r <= 1'b1;
      lineDriverModeOutA_r <= 1'b1;
      lineDriverModeOutB_r <= 1'b1;
      duOe_r <= 1'b0;
      pdoOut_r <= 1'b0;
      pdoOe_r <= 1'b0;
      fixedOutputPin_r <= 1'b0;
      clkFail_r <= 1'b0;
      idleInsert_r <= 1'b0;
      idleCode_r <= `RSS_IDLE_ALAW;
      rxMute_r <= 1'b0;
    end else if (clkEn) begin
      coreRst_r <= coreRst_nxt;
      gciRst_r <= gciRst_nxt;
      // clock fail touches only the dsp, never config or link state
      dspRst_r <= coreRst_nxt | clkFail_nxt;
      extIndication_r <= coreRst_nxt | ~(modeApplied_r[`RSS_CI_CONV] | modeApplied_r[`RSS_CI_RING]);
      powerDenial_r <= coreRst_nxt | ~powerUp_nxt;
      // high-voltage mode lines sit at their high level in reset
      lineDriverModeOutA_r <= coreRst_nxt | ~modeApplied_r[`RSS_CI_CONV];
      lineDriverModeOutB_r <= coreRst_nxt | ~modeApplied_r[`RSS_CI_RING];
      duOe_r <= ~coreRst_nxt & duDriveReq;
      pdoOut_r <= pdoLevel;
      pdoOe_r <= ~coreRst_nxt & pdoDriveReq;
      fixedOutputPin_r <= ~coreRst_nxt & modeApplied_r[`RSS_CI_O1];
      clkFail_r <= clkFail_nxt;
      idleInsert_r <= clkFail_nxt & activeMode;
      idleCode_r <= lawMu_nxt ? `RSS_IDLE_ULAW : `RSS_IDLE_ALAW;
      rxMute_r <= clkFail_nxt & activeMode;
    end
  end

  // coefficient store and its access ports
  rss_coef_if cif ();
  rss_coef_mem u_mem (.core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn), .cif(cif));
  logic [4:0] chkAddr_r;
  logic chkVal_r; // data on port B belongs to the sweep
  logic chkLast_r;
  logic fixSelDly_r;
  logic [15:0] fixedWord_r;
  assign cif.wrEn = coefWrEn;
  assign cif.wrAddr = coefWrAddr;
  assign cif.wrData = coefWrData;
  assign cif.rdAddrA = dspCoefAddr;
  // readback and checksum always see the programmed set
  assign cif.rdAddrB = chksumBusy_r ? chkAddr_r : readAddr;
  wire chkEnd = chksumBusy_r && (chkAddr_r == 5'(`RSS_COEF_WORDS - 1));
  wire [15:0] fixedLook = (dspCoefAddr < 5'(`RSS_COEF_WORDS)) ? FIXED_TABLE[dspCoefAddr*16 +: 16] : 16'h0000;

  // dsp fetch: fixed word and store word share the same two-cycle latency
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fixedWord_r <= 16'h0000;
      fixSelDly_r <= 1'b1;
      dspCoef_r <= 16'h0000;
      readData_r <= 16'h0000;
    end else if (clkEn) begin
      fixedWord_r <= fixedLook;
      fixSelDly_r <= fixedCoeffSelect_r;
      dspCoef_r <= fixSelDly_r ? fixedWord_r : cif.rdDataA;
      readData_r <= cif.rdDataB;
    end
  end

  // checksum sweep over every stored word, sum modulo 2^16
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      chksumBusy_r <= 1'b0;
      chkAddr_r <= 5'h00;
      chkVal_r <= 1'b0;
      chkLast_r <= 1'b0;
      chksum_r <= 16'h0000;
    end else if (clkEn) begin
      chkVal_r <= chksumBusy_r;
      chkLast_r <= chkEnd;
      if (chksumStart && !chksumBusy_r) begin
        chksumBusy_r <= 1'b1;
        chkAddr_r <= 5'h00;
        chksum_r <= 16'h0000;
      end else begin
        if (chkEnd) chksumBusy_r <= 1'b0;
        if (chksumBusy_r) chkAddr_r <= chkAddr_r + 5'h01;
        if (chkVal_r) chksum_r <= chksum_r + cif.rdDataB;
      end
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_resetEnds;
    clkEn && $fell(coreRst_r);
  endsequence
  a_reset_pin_states: assert property (coreRst_r |-> (!duOe_r && !pdoOe_r && lineDriverModeOutA_r
    && lineDriverModeOutB_r && !fixedOutputPin_r)) else $error("pin states wrong during reset");
  a_reset_power_denial: assert property (coreRst_r |-> (extIndication_r && powerDenial_r))
    else $error("reset without power denial");
  a_pin_filter_len: assert property ($rose(pinRst_r) |-> $past(mrFiltCnt_r) == 4'(MR_CYC - 1))
    else $error("reset pin accepted too early");
  a_sw_reset_wait: assert property ((state_r == ST_SOFTWAIT && cmdBusy && !hardSrc) |=> !coreRst_r)
    else $error("soft reset during busy command");
  a_clkfail_hold: assert property ((clkEn && clkFail_r && !fscRise) |=> clkFail_r && dspRst_r)
    else $error("clock fail reset dropped without good frame");
  a_idle_voice: assert property (idleInsert_r |-> (rxMute_r && clkFail_r
    && idleCode_r == (lawMu_r ? `RSS_IDLE_ULAW : `RSS_IDLE_ALAW))) else $error("idle insertion wrong");
  a_fixed_coeff_select_after_reset: assert property (s_resetEnds |-> fixedCoeffSelect_r && fixSelDly_r)
    else $error("fixed coefficients not selected");
  a_reset_flag_set: assert property (s_resetEnds |-> rstFlag_r)
    else $error("reset bit not set");
  a_startup_regs: assert property (s_resetEnds |-> (!powerUpBit_r && ioDir_r == `RSS_IODIR_RST
    && sigMask_r == `RSS_SIGMASK_RST && ciUp_r == `RSS_CIUP_RST)) else $error("start-up register values wrong");
  a_ci_two_frames: assert property ((clkEn && ciRxStrobe && ciDownRx != ciPrev_r && !gciRst_nxt)
    |=> $stable(ciLatch_r)) else $error("command latched from one frame");
  a_mode_delay: assert property ((frmSinceRst_r != 2'(`RSS_MODE_DELAY_FRM)) |-> modeApplied_r == 6'h00)
    else $error("mode applied too early");
endmodule

// >>> dv/rss_line_ctl.sv
// line-card controller model: data clock and frame sync
// assumes the bench raises failMode to starve frames
`timescale 1ns/100ps
module rss_line_ctl (
  // fault control
  input wire logic failMode,
  // backplane clocks
  output logic dataClk,
  output logic frameSync
);
  // free-running 125 ns data clock, 256 per frame, 200 when failing
  initial begin
    dataClk = 0;
    forever begin
      for (int i = 0; i < (failMode ? 200 : 256); i++) begin
        frameSync = (i == 0);
        #62.5 dataClk = 1;
        #62.5 dataClk = 0;
      end
    end
  end
endmodule

// >>> dv/reset_startup_sequencer_bench.sv
// bench: reset sources, pin states, clock fail, defaults
// assumes the line-card model drives the link clocks
`timescale 1ns/100ps
module reset_startup_sequencer_bench;
  import rss_pkg::*;
  // inputs, changed on the falling edge
  logic core_clk = 0, arst_n = 0, clkEn = 1, powerOnDet = 0, sel4M = 0, masterResetPin = 0, cmdBusy = 0;
  logic ciRxStrobe = 0, failMode = 0, drv = 1;
  logic [8:0] stb = '0; // one strobe per command
  logic [7:0] d = '0; // shared command data
  logic [5:0] ci = '0;
  logic [4:0] a = '0;
  // outputs
  logic dataClk, frameSync, coreRst_r, gciRst_r, dspRst_r, extIndication_r, powerDenial_r, clkFail_r, idleInsert_r;
  logic lineDriverModeOutA_r, lineDriverModeOutB_r, duOe_r, pdoOe_r, fixedOutputPin_r, rxMute_r, rstFlag_r;
  logic fixedCoeffSelect_r, powerUpBit_r, lawMu_r, chksumBusy_r, pdoOut_r;
  logic [1:0] ioDir_r;
  logic [5:0] sigMask_r, ciUp_r, modeApplied_r;
  logic [7:0] idleCode_r;
  logic [15:0] dspCoef_r, readData_r, chksum_r;
  rss_dflt_s defaults_r;
  int errors = 0, n_checks = 0;
  wire [8:0] pins = {coreRst_r, gciRst_r, extIndication_r, powerDenial_r, lineDriverModeOutA_r,
    lineDriverModeOutB_r, duOe_r, pdoOe_r, fixedOutputPin_r};
  always #4 core_clk = ~core_clk;
  rss_line_ctl u_ctl (.failMode, .dataClk, .frameSync);
  // commands share one data byte; fetch, readback and write share one address
  rss_reset_startup #(.FRAME_TMO_CYC(6000)) u_dut (.*, .sopWrite(stb[0]), .sopData(d), .cr6Write(stb[1]),
    .cr6Data(d), .cr1Write(stb[2]), .cr1PowerUp(d[0]), .ioDirWrite(stb[3]), .ioDirData(d[1:0]),
    .sigMaskWrite(stb[4]), .sigMaskData(d[5:0]), .lawWrite(stb[5]), .lawMuData(d[0]), .ciUpLoad(stb[6]),
    .ciUpData(d[5:0]), .ciDownRx(ci), .duDriveReq(drv), .pdoDriveReq(drv), .pdoLevel(drv), .coefWrEn(stb[7]),
    .coefWrAddr(a), .coefWrData({d, d}), .dspCoefAddr(a), .readAddr(a), .chksumStart(stb[8]));
  task automatic chk(string what, logic [127:0] got, logic [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask
  // one-cycle command strobe
  task automatic pulse(int k);
    @(negedge core_clk) stb[k] = 1;
    @(negedge core_clk) stb[k] = 0;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    cyc(6);
    chk("reset pins", pins, 9'h1F8);
    cyc(2);
    arst_n = 1;
    cyc(12000); // first frame after reset may flag a fail
    chk("reset state", {rstFlag_r, fixedCoeffSelect_r, powerUpBit_r, ioDir_r, sigMask_r, ciUp_r, lawMu_r,
      clkFail_r}, {5'h18, 6'h3F, 8'h00});
    chk("defaults", defaults_r, {8'h0A, 8'h14, 8'h2A, 8'hDC, 8'h4D, 8'h64, 8'h4D, 8'h19, 8'h41, 8'h10,
      8'h0A, 8'h00, 8'hF9, 2'b11});
    d = 8'h12;
    for (int w = 0; w < 23; w++) begin
      a = 5'(w);
      pulse(7);
    end
    a = 5'h00;
    cyc(3);
    chk("fixed ka", {dspCoef_r, readData_r}, 32'h0E001212);
    a = 5'h0E;
    cyc(3);
    chk("fixed grx", dspCoef_r, 16'h0060);
    pulse(8); // sweep while the fixed set is selected
    cyc(3);
    chk("sum busy", chksumBusy_r, 1'b1);
    cyc(24);
    chk("checksum", {chksumBusy_r, chksum_r}, 17'h09F9E);
    a = 5'h00;
    d = 8'h00;
    pulse(1);
    pulse(0);
    cyc(3);
    chk("programmed", {dspCoef_r, fixedCoeffSelect_r, rstFlag_r}, 18'h04848);
    d = 8'h2B;
    for (int k = 2; k < 7; k++) pulse(k);
    cyc(2);
    chk("config", {powerUpBit_r, ioDir_r, sigMask_r, lawMu_r, ciUp_r, idleCode_r}, 24'hF5EBFF);
    chk("drives", {pdoOut_r, pdoOe_r, duOe_r}, 3'b111);
    $display("test start-up done");
    d = 8'h00;
    pulse(5);
    cmdBusy = 1;
    d = 8'h10;
    pulse(0);
    cyc(5);
    chk("soft wait", coreRst_r, 1'b0);
    cmdBusy = 0;
    cyc(3);
    chk("soft pins", pins, 9'h178);
    cyc(20);
    chk("soft after", {coreRst_r, rstFlag_r, fixedCoeffSelect_r, powerUpBit_r, ioDir_r, sigMask_r, ciUp_r},
      {6'h18, 6'h3F, 6'h00});
    masterResetPin = 1;
    cyc(10); // 80 ns spike
    masterResetPin = 0;
    cyc(20);
    chk("spike", coreRst_r, 1'b0);
    masterResetPin = 1;
    cyc(250); // held for 2 us
    chk("pin pins", pins, 9'h1F8);
    masterResetPin = 0;
    cyc(10);
    chk("pin release", coreRst_r, 1'b0);
    $display("test resets done");
    ci = 6'b010001;
    repeat (4) begin
      @(posedge frameSync);
      @(negedge core_clk) ciRxStrobe = 1;
      @(negedge core_clk) ciRxStrobe = 0;
    end
    cyc(4);
    chk("mode", {modeApplied_r, lineDriverModeOutA_r, lineDriverModeOutB_r, fixedOutputPin_r}, 9'h08B);
    failMode = 1;
    for (int i = 0; i < 20000 && clkFail_r !== 1'b1; i++) cyc(1);
    chk("clock fail", {dspRst_r, coreRst_r, idleInsert_r, rxMute_r, idleCode_r, fixedCoeffSelect_r,
      modeApplied_r}, 19'h5EAD1);
    failMode = 0;
    for (int i = 0; i < 20000 && clkFail_r !== 1'b0; i++) cyc(1);
    chk("clock good", {dspRst_r, idleInsert_r, rxMute_r}, 3'b000);
    sel4M = 1; // 256 edges now read as a short 4 MHz frame
    for (int i = 0; i < 20000 && clkFail_r !== 1'b1; i++) cyc(1);
    chk("rate select", {clkFail_r, dspRst_r}, 2'b11);
    sel4M = 0;
    powerOnDet = 1;
    cyc(5);
    chk("power-on", pins, 9'h1F8);
    powerOnDet = 0;
    cyc(5);
    clkEn = 0; // frozen: this clear must not land
    d = 8'h00;
    pulse(1);
    clkEn = 1;
    chk("frozen", {coreRst_r, fixedCoeffSelect_r}, 2'b01);
    $display("test clock fail done");
    finish_test();
  end
  // hang guard, well past the planned run
  initial begin
    #700000;
    errors++;
    finish_test();
  end
endmodule
